// [logic/flash_cmd_pkg.sv]
/*
    Shared constants of the serial flash command core: opcodes, status
    bit positions, frame lengths, dummy clock counts and timing counts.
    Assumes a 125 MHz system clock; the link clock is free of any ratio.
*/
package flash_cmd_pkg;

    // Instruction opcodes
    localparam logic [7:0] WRITE_ENABLE_CMD     = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD    = 8'h04;
    localparam logic [7:0] VOL_WRITE_ENABLE_CMD = 8'h50;
    localparam logic [7:0] STATUS1_READ_CMD     = 8'h05;
    localparam logic [7:0] STATUS2_READ_CMD     = 8'h35;
    localparam logic [7:0] STATUS_WRITE_CMD     = 8'h01;
    localparam logic [7:0] STATUS2_WRITE_CMD    = 8'h31;
    localparam logic [7:0] READ_DATA_CMD        = 8'h03;
    localparam logic [7:0] FAST_READ_CMD        = 8'h0B;
    localparam logic [7:0] SET_READ_PARAM_CMD   = 8'hC0;
    localparam logic [7:0] RESET_ENABLE_CMD     = 8'h66;
    localparam logic [7:0] RESET_CMD            = 8'h99;

    // Status word positions, register 2 in the upper byte
    localparam int unsigned BUSY_BIT       = 0;
    localparam int unsigned LATCH_BIT      = 1;
    localparam int unsigned PROTECT_HI_BIT = 8;
    localparam int unsigned QUAD_BIT       = 9;
    localparam int unsigned LOCK_BIT       = 10;
    localparam int unsigned DRIVE0_BIT     = 11;
    localparam int unsigned DRIVE1_BIT     = 12;
    localparam int unsigned COMPLEMENT_BIT = 14;
    localparam logic [15:0] SR_WRITE_MASK  = 16'h5FFC;
    localparam logic [15:0] NV_STATUS_INIT = 16'h0000;

    // Read parameter field position and dummy clocks
    localparam int unsigned RP_DUMMY_LSB      = 4;
    localparam logic [1:0]  DUMMY_SEL_INIT    = 2'h0;
    localparam logic [3:0]  SPI_DUMMY_CLOCKS  = 4'h8;

    // Frame lengths in bits, counter saturation
    localparam logic [6:0] BYTE_BITS    = 7'h08;
    localparam logic [6:0] SR_BYTE_END  = 7'h10;
    localparam logic [6:0] SR_WORD_END  = 7'h18;
    localparam logic [6:0] ADDR_END     = 7'h20;
    localparam logic [6:0] CNT_SAT      = 7'h78;

    // Output enables on the data lanes
    localparam logic [3:0] SINGLE_OUT_OE = 4'h2;
    localparam logic [3:0] QUAD_OUT_OE   = 4'hF;

    // Timing, system clock period in ns
    localparam int unsigned CLK_PERIOD_NS     = 8;
    localparam int unsigned T_W_NS            = 2000000;
    localparam int unsigned T_W_CYCLES        = T_W_NS / CLK_PERIOD_NS;
    localparam int unsigned T_REFRESH_NS      = 50;
    localparam int unsigned T_REFRESH_CYCLES  =
        (T_REFRESH_NS / CLK_PERIOD_NS < 1) ? 1 : T_REFRESH_NS / CLK_PERIOD_NS;

endpackage

// [logic/flash_mem_if.sv]
/*
    Connection between the command core and its data array: a write
    port on the system clock and a read port on the link clock.
    Assumes the user keeps the write port idle while reads are wanted.
*/
`timescale 1ns/100ps
interface flash_mem_if
#(
    parameter int unsigned AW = 10
);
    logic          we;
    logic [AW-1:0] waddr;
    logic [7:0]    wdata;
    logic [AW-1:0] raddr;
    logic [7:0]    rdata;

    modport ctrl  (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [logic/bit_sync.sv]
/*
    Two flip-flop synchroniser for a group of level signals.
    Assumes each bit is meaningful alone; words need a qualifier.
*/
`timescale 1ns/100ps
module bit_sync
#(
    parameter int unsigned W = 1
)
(
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] held;
    } sync_s;

    sync_s s;
    sync_s next_s;

    // First stage feeds only the second stage
    always_comb
    begin
        next_s.meta = d;
        next_s.held = s.meta;
    end

    always_ff @(posedge clk)
        s <= next_s;

    assign q = s.held;
endmodule

// [logic/flash_array.sv]
/*
    Byte array behind the read instructions: written on the system
    clock, read on the link clock with registered read data.
    Assumes the read address is presented one link edge ahead of use.
*/
`timescale 1ns/100ps
module flash_array
#(
    parameter int unsigned AW = 10
)
(
    input  wire logic   wclk,
    input  wire logic   rclk,
    flash_mem_if.store  bus
);
    logic [7:0] cells [0:(1 << AW) - 1];

    // Load port, system clock
    always_ff @(posedge wclk)
    begin
        if (bus.we)
            cells[bus.waddr] <= bus.wdata;
    end

    // Registered read, link clock
    always_ff @(posedge rclk)
        bus.rdata <= cells[bus.raddr];
endmodule

// [logic/flash_cmd_core.sv]
/*
    Command core of a serial flash: write enable and disable, volatile
    write enable, status read and write, set read parameters, software
    reset, Read Data in single-line mode only, Fast Read in single-line and four-bit mode.
    Assumes sclk toggles only while cs_n is low, cs_n stays high for at
    least four clk periods between frames, and cs_n is high during rst.
*/
`timescale 1ns/100ps
module flash_cmd_core
    import flash_cmd_pkg::*;
#(
    parameter int unsigned MEM_AW         = 10,
    parameter int unsigned WRITE_CYCLES   = T_W_CYCLES,
    parameter bit          CLEAR_ON_SHORT = 1'b0,
    parameter logic [15:0] NV_INIT        = NV_STATUS_INIT
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic [3:0]        dq_in,
    output logic      [3:0]        dq_out,
    output logic      [3:0]        dq_oe,
    input  wire logic              four_bit_command_mode,
    input  wire logic              load_en,
    input  wire logic [MEM_AW-1:0] load_addr,
    input  wire logic [7:0]        load_data,
    output logic      [15:0]       status_view,
    output logic                   write_in_progress
);
    localparam int unsigned TW = $clog2(WRITE_CYCLES + 1);

    // System clock state
    typedef struct packed {
        logic [15:0]   nv;
        logic [15:0]   act;
        logic          write_latch;
        logic          write_in_progress;
        logic          vol_armed;
        logic          rst_armed;
        logic [1:0]    dsel;
        logic          pend_vol;
        logic [15:0]   pend;
        logic [TW-1:0] timer;
        logic          cs_prev;
        logic          wide;
        logic [15:0]   view;
    } core_s;

    localparam core_s CORE_INIT = '{nv: NV_INIT, act: NV_INIT, cs_prev: 1'b1,
                                    dsel: DUMMY_SEL_INIT, view: NV_INIT, default: '0};

    typedef enum logic [2:0] {L_CMD, L_ADDR, L_DUMMY, L_MEM, L_STAT, L_SINK} link_e;

    // Link clock state, rising edge
    typedef struct packed {
        link_e       st;
        logic [6:0]  cnt;
        logic [23:0] sr;
        logic [7:0]  op;
        logic [23:0] addr;
        logic [3:0]  dly;
        logic [2:0]  pos;
        logic        stat2;
    } link_s;

    core_s       c;
    core_s       next_core;
    link_s       l;
    link_s       link_base;
    link_s       next_link;
    logic        fresh;
    logic        cs_s;
    logic        frame_end;
    logic        single;
    logic        busy;
    logic        len_ok;
    logic        quad_fail;
    logic [15:0] base;
    logic [15:0] wdata;
    logic [15:0] newv;
    logic [18:0] lk_view;
    logic        lk_wide;
    logic [1:0]  lk_dsel;
    logic [15:0] lk_stat;
    logic [2:0]  w;
    logic [7:0]  out_byte;

    flash_mem_if #(.AW(MEM_AW)) mbus ();

    // Merge written data into the old word; one-time bits only rise
    function automatic logic [15:0] merge_status(
        input logic [15:0] old,
        input logic [15:0] data,
        input logic        vol
    );
        logic [15:0] r;
        r = (old & ~SR_WRITE_MASK) | (data & SR_WRITE_MASK);
        r[LOCK_BIT] = r[LOCK_BIT] | old[LOCK_BIT];
        if (vol)
            r[PROTECT_HI_BIT] = r[PROTECT_HI_BIT] | old[PROTECT_HI_BIT];
        return r;
    endfunction

    // Dummy clocks of a fast read
    function automatic logic [3:0] dummy_clocks(
        input logic       wide,
        input logic [1:0] sel
    );
        logic [3:0] d;
        d = wide ? ({1'b0, sel, 1'b0} + 4'h2) : SPI_DUMMY_CLOCKS;
        return d;
    endfunction

    // Lane values for one output clock
    function automatic logic [3:0] unit_sel(
        input logic [7:0] b,
        input logic [2:0] p,
        input logic       wide
    );
        logic [3:0] u;
        u = wide ? 4'(b >> (p - 3'h3)) : {2'h0, b[p], 1'h0};
        return u;
    endfunction

    // Frame end seen through two flip-flops on the system clock
    bit_sync #(.W(1)) u_cs_sync
    (
        .clk (clk),
        .d   (cs_n),
        .q   (cs_s)
    );

    // Status, mode and dummy select carried to the link clock
    bit_sync #(.W(19)) u_view_sync
    (
        .clk (sclk),
        .d   ({c.wide, c.dsel, c.view}),
        .q   (lk_view)
    );

    assign {lk_wide, lk_dsel, lk_stat} = lk_view;

    // Data array; load port on the system clock
    assign mbus.we    = load_en;
    assign mbus.waddr = load_addr;
    assign mbus.wdata = load_data;
    assign mbus.raddr = next_link.addr[MEM_AW-1:0];

    flash_array #(.AW(MEM_AW)) u_array
    (
        .wclk (clk),
        .rclk (sclk),
        .bus  (mbus.store)
    );

    // Link fields are read only once cs_n is high and sclk has stopped
    assign frame_end = cs_s & ~c.cs_prev;
    assign single    = (l.cnt == BYTE_BITS);
    assign busy      = (c.timer != '0);

    // Status write operands
    always_comb
    begin
        base   = c.vol_armed ? c.act : c.nv;
        len_ok = (l.op == STATUS_WRITE_CMD) ? (l.cnt == SR_BYTE_END || l.cnt == SR_WORD_END)
                                            : (l.cnt == SR_BYTE_END);
        if (l.op == STATUS2_WRITE_CMD)
            wdata = {l.sr[7:0], base[7:0]};
        else if (l.cnt == SR_WORD_END)
            wdata = {l.sr[7:0], l.sr[15:8]};
        else
        begin
            wdata = {base[15:8], l.sr[7:0]};
            if (CLEAR_ON_SHORT)
            begin
                wdata[DRIVE0_BIT]     = 1'b0;
                wdata[DRIVE1_BIT]     = 1'b0;
                wdata[COMPLEMENT_BIT] = 1'b0;
                wdata[QUAD_BIT]       = 1'b0;
            end
        end
        newv      = merge_status(base, wdata, c.vol_armed);
        quad_fail = c.wide & ~newv[QUAD_BIT];
    end

    // Command execution on the system clock
    always_comb
    begin
        next_core         = c;
        next_core.cs_prev = cs_s;
        next_core.wide    = four_bit_command_mode;
        next_core.view    = {c.act[15:2], c.write_latch, c.write_in_progress};

        // Timed cycles; busy flag never covers the volatile refresh
        if (busy)
        begin
            next_core.timer = c.timer - 1'b1;
            if (c.timer == TW'(1))
            begin
                next_core.act = c.pend;
                if (c.pend_vol)
                    next_core.pend_vol = 1'b0;
                else
                begin
                    next_core.nv                = c.pend;
                    next_core.write_in_progress = 1'b0;
                    next_core.write_latch       = 1'b0;
                end
            end
        end

        if (frame_end)
        begin
            next_core.rst_armed = (l.op == RESET_ENABLE_CMD) && single;
            case (l.op)
                WRITE_ENABLE_CMD:
                begin
                    if (single && !busy)
                        next_core.write_latch = 1'b1;
                end
                WRITE_DISABLE_CMD:
                begin
                    if (single && !busy)
                        next_core.write_latch = 1'b0;
                end
                VOL_WRITE_ENABLE_CMD:
                begin
                    if (single && !busy)
                        next_core.vol_armed = 1'b1;
                end
                STATUS_WRITE_CMD, STATUS2_WRITE_CMD:
                begin
                    // An abandoned write still consumes the volatile arm
                    next_core.vol_armed = 1'b0;
                    if (len_ok && !busy && !quad_fail)
                    begin
                        if (c.vol_armed)
                        begin
                            next_core.pend     = newv;
                            next_core.pend_vol = 1'b1;
                            next_core.timer    = TW'(T_REFRESH_CYCLES);
                        end
                        else if (c.write_latch)
                        begin
                            next_core.pend              = newv;
                            next_core.write_in_progress = 1'b1;
                            next_core.timer             = TW'(WRITE_CYCLES);
                        end
                    end
                end
                SET_READ_PARAM_CMD:
                begin
                    if (l.cnt == SR_BYTE_END && !busy)
                        next_core.dsel = l.sr[RP_DUMMY_LSB +: 2];
                end
                RESET_CMD:
                begin
                    // A running non-volatile cycle is left to finish
                    if (single && c.rst_armed)
                    begin
                        next_core.act         = next_core.nv;
                        next_core.write_latch = 1'b0;
                        next_core.vol_armed   = 1'b0;
                        next_core.dsel        = DUMMY_SEL_INIT;
                        if (c.pend_vol)
                        begin
                            next_core.pend_vol = 1'b0;
                            next_core.timer    = '0;
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            c <= CORE_INIT;
        else
            c <= next_core;
    end

    assign status_view       = c.view;
    assign write_in_progress = c.write_in_progress;

    // Marks the first rising sclk edge of a frame
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            fresh <= 1'b1;
        else
            fresh <= 1'b0;
    end

    assign w = lk_wide ? 3'h4 : 3'h1;

    // Link sequencer, rising sclk edges
    always_comb
    begin
        link_base = l;
        if (fresh)
        begin
            link_base.st  = L_CMD;
            link_base.cnt = '0;
            link_base.op  = 8'h00; // A cut frame must not replay the previous opcode
        end
        next_link     = link_base;
        next_link.sr  = lk_wide ? {link_base.sr[19:0], dq_in} : {link_base.sr[22:0], dq_in[0]};
        next_link.cnt = (link_base.cnt >= CNT_SAT) ? link_base.cnt : link_base.cnt + {4'h0, w};
        case (link_base.st)
            L_CMD:
            begin
                if (next_link.cnt == BYTE_BITS)
                begin
                    next_link.op    = next_link.sr[7:0];
                    next_link.pos   = 3'h7;
                    next_link.stat2 = (next_link.sr[7:0] == STATUS2_READ_CMD);
                    case (next_link.sr[7:0])
                        STATUS1_READ_CMD, STATUS2_READ_CMD:
                            next_link.st = L_STAT;
                        READ_DATA_CMD:
                            next_link.st = (lk_wide || lk_stat[BUSY_BIT]) ? L_SINK : L_ADDR;
                        FAST_READ_CMD:
                            next_link.st = lk_stat[BUSY_BIT] ? L_SINK : L_ADDR;
                        default:
                            next_link.st = L_SINK;
                    endcase
                end
            end
            L_ADDR:
            begin
                if (next_link.cnt == ADDR_END)
                begin
                    next_link.addr = next_link.sr;
                    if (link_base.op == FAST_READ_CMD)
                    begin
                        next_link.st  = L_DUMMY;
                        next_link.dly = dummy_clocks(lk_wide, lk_dsel);
                    end
                    else
                        next_link.st = L_MEM;
                end
            end
            L_DUMMY:
            begin
                // Input lanes are shifted but never interpreted here
                next_link.dly = link_base.dly - 4'h1;
                if (link_base.dly == 4'h1)
                    next_link.st = L_MEM;
            end
            L_MEM:
            begin
                if (link_base.pos < w)
                begin
                    next_link.pos  = 3'h7;
                    next_link.addr = link_base.addr + 24'h000001;
                end
                else
                    next_link.pos = link_base.pos - w;
            end
            L_STAT:
            begin
                // Same byte again until chip select rises
                next_link.pos = (link_base.pos < w) ? 3'h7 : link_base.pos - w;
            end
            default:
            begin
            end
        endcase
    end

    always_ff @(posedge sclk)
        l <= next_link;

    assign out_byte = (l.st == L_STAT) ? (l.stat2 ? lk_stat[15:8] : lk_stat[7:0]) : mbus.rdata;

    // Falling-edge drivers; chip select high releases the lanes at once
    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            dq_out <= 4'h0;
            dq_oe  <= 4'h0;
        end
        else if (l.st == L_MEM || l.st == L_STAT)
        begin
            dq_out <= unit_sel(out_byte, l.pos, lk_wide);
            dq_oe  <= lk_wide ? QUAD_OUT_OE : SINGLE_OUT_OE;
        end
        else
        begin
            dq_out <= 4'h0;
            dq_oe  <= 4'h0;
        end
    end
endmodule

// [verification/flash_cmd_core_assertions.sv]
/*
    Concurrent checks on the ports of the flash command core.
    Assumes a bind from the bench and single-line host traffic.
*/
`timescale 1ns/100ps
module flash_cmd_core_assertions
    import flash_cmd_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = 20
)
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        cs_n,
    input wire logic [3:0]  dq_out,
    input wire logic [3:0]  dq_oe,
    input wire logic        four_bit_command_mode,
    input wire logic [15:0] status_view,
    input wire logic        write_in_progress
);
    int unsigned busy_cnt;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Length of the current busy stretch, too long for a repetition
    always_ff @(posedge clk)
        busy_cnt <= (rst || !write_in_progress) ? 0 : busy_cnt + 1;

    // Steps the properties are built from
    sequence cycle_end_s;
        $fell(write_in_progress);
    endsequence
    sequence frame_closed_s;
        cs_n ##1 cs_n;
    endsequence

    lanes_idle_a: assert property (frame_closed_s |-> dq_oe == 4'h0 && dq_out == 4'h0)
        else $error("lanes driven with chip select high");
    fixed_zero_a: assert property (status_view[15] == 1'b0 && status_view[13] == 1'b0)
        else $error("read-only status bit set");
    lock_sticky_a: assert property ($past(status_view[LOCK_BIT]) |-> status_view[LOCK_BIT])
        else $error("security lock cleared");
    busy_len_a: assert property (cycle_end_s |-> busy_cnt + 2 >= WRITE_CYCLES && busy_cnt <= WRITE_CYCLES + 2)
        else $error("write cycle length wrong");
    latch_clear_a: assert property (cycle_end_s |-> ##[0:3] !status_view[LATCH_BIT])
        else $error("write latch kept after cycle");
    busy_shown_a: assert property (write_in_progress |-> ##[0:2] status_view[BUSY_BIT])
        else $error("busy bit not shown in status");
    busy_start_a: assert property ($rose(write_in_progress) |-> $past(cs_n, 2) && cs_n)
        else $error("write cycle began inside a frame");
    single_lane_a: assert property (!four_bit_command_mode && !cs_n |-> dq_oe == 4'h0 || dq_oe == SINGLE_OUT_OE)
        else $error("wrong lanes enabled in single-line mode");
endmodule

// [verification/spi_host_model.sv]
/*
    Host controller model: mode 0 frames, MSB first, single line.
    Assumes the bench calls frame() one at a time; an undriven data
    line has no pull and drifts away from its last level.
*/
`timescale 1ns/100ps
module spi_host_model
(
    output logic            sclk,
    output logic            cs_n,
    output logic [3:0]      dq_in,
    input  wire logic [3:0] dq_out,
    input  wire logic [3:0] dq_oe
);
    logic [63:0] rx;

    // Idle link: clock low and still, chip select high
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        dq_in = 4'hA;
    end

    // One frame of n bits; reply captured on each rising edge
    task automatic frame(input int n, input logic [63:0] tx);
        rx = 64'h0;
        #3 cs_n = 1'b0; // Off the system clock edge
        for (int i = n - 1; i >= 0; i--)
        begin
            dq_in[0] = tx[i];
            #62.5 sclk = 1'b1;
            rx = {rx[62:0], dq_oe[1] ? dq_out[1] : ~rx[0]}; // Released line shows no stale value
            #62.5 sclk = 1'b0;
        end
        #62.5 cs_n = 1'b1;
        dq_in = ~dq_in; // Released line has no pull, so never a stale value
        #80;
    endtask
endmodule

// [verification/flash_cmd_core_tb.sv]
/*
    Self-checking bench of the flash command core with a host model.
    Assumes a shortened write cycle and single-line mode only.
*/
`timescale 1ns/100ps
module flash_cmd_core_tb;
    localparam int unsigned WCYC = 2000;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        load_en = 1'b0;
    logic [9:0]  load_addr = 10'h000;
    logic [7:0]  load_data = 8'h00;
    logic        sclk, cs_n, write_in_progress, oe_seen, wip_seen;
    logic [3:0]  dq_in, dq_out, dq_oe;
    logic [15:0] status_view;
    int          num_errors = 0;
    int          n_checks = 0;

    flash_cmd_core #(.WRITE_CYCLES(WCYC)) dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .four_bit_command_mode(1'b0), .load_en(load_en), .load_addr(load_addr),
        .load_data(load_data), .status_view(status_view), .write_in_progress(write_in_progress));
    spi_host_model host (.sclk(sclk), .cs_n(cs_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

    always #4 clk = ~clk;

    // Sticky monitors for outputs that must stay quiet
    always @(posedge clk)
    begin
        if (dq_oe !== 4'h0) oe_seen = 1'b1;
        if (write_in_progress !== 1'b0) wip_seen = 1'b1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Bounded wait for the timed cycle to finish
    task automatic wait_idle;
        for (int i = 0; i < 3000 && write_in_progress !== 1'b0; i++) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask

    task automatic load(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        load_en <= 1'b1;
        load_addr <= a;
        load_data <= d;
        @(posedge clk);
        load_en <= 1'b0;
    endtask

    task automatic t_latch;
        host.frame(8, 64'h06);
        check("status_view", status_view, 16'h0002);
        host.frame(8, 64'h04);
        check("status_view", status_view, 16'h0000);
        host.frame(8, 64'h50);
        check("status_view", status_view, 16'h0000);
        $display("test latch done");
    endtask

    // Short frame spends the volatile arm; then no latch at all
    task automatic t_refuse;
        host.frame(20, {8'h01, 12'hFFF});
        check("status_view", status_view, 16'h0000);
        host.frame(24, {8'h01, 16'hFFFF});
        check("status_view", status_view, 16'h0000);
        $display("test refuse done");
    endtask

    task automatic t_nv;
        host.frame(8, 64'h06);
        host.frame(24, {8'h01, 16'hFFFF});
        check("write_in_progress", write_in_progress, 1'b1);
        host.frame(24, {8'h05, 16'h0000});
        check("status during cycle", host.rx[15:0], 16'h0303);
        oe_seen = 1'b0;
        host.frame(40, {8'h03, 32'h0});
        check("output during cycle", oe_seen, 1'b0);
        wait_idle();
        check("status_view", status_view, 16'h5FFC);
        $display("test nv write done");
    endtask

    task automatic t_status;
        host.frame(24, {8'h35, 16'h0000});
        check("status2 stream", host.rx[15:0], 16'h5F5F);
        host.frame(32, {8'h05, 24'h0});
        check("status1 stream", host.rx[23:0], 24'hFCFCFC);
        $display("test status read done");
    endtask

    task automatic t_vol;
        wip_seen = 1'b0;
        host.frame(8, 64'h50);
        host.frame(24, {8'h01, 16'h0000});
        repeat (10) @(posedge clk);
        check("busy during refresh", wip_seen, 1'b0);
        check("status_view", status_view, 16'h0500);
        host.frame(8, 64'h66);
        host.frame(8, 64'h99);
        check("status_view", status_view, 16'h5FFC);
        $display("test volatile write done");
    endtask

    task automatic t_eight;
        host.frame(8, 64'h06);
        host.frame(16, {8'h01, 8'h00});
        wait_idle();
        check("status_view", status_view, 16'h5F00);
        host.frame(8, 64'h06);
        host.frame(16, {8'h31, 8'h02});
        wait_idle();
        check("status_view", status_view, 16'h0600);
        $display("test eight bit write done");
    endtask

    // Stream across the top of the array, then fast read with all-ones dummy bits
    task automatic t_read;
        load(10'h3FE, 8'hA5);
        load(10'h3FF, 8'h3C);
        load(10'h000, 8'h96);
        host.frame(56, {8'h03, 24'h0003FE, 24'h0});
        check("read stream", host.rx[23:0], 24'hA53C96);
        host.frame(48, {8'h0B, 24'h0003FF, 8'hFF, 8'h00});
        check("fast read", host.rx[7:0], 8'h3C);
        $display("test read done");
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_latch();
        t_refuse();
        t_nv();
        t_status();
        t_vol();
        t_eight();
        t_read();
        report_and_stop();
    end

    // Watchdog well beyond the expected run
    initial
    begin
        #400000;
        num_errors++;
        report_and_stop();
    end
endmodule

bind flash_cmd_core flash_cmd_core_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) chk (.clk(clk), .rst(rst),
    .cs_n(cs_n), .dq_out(dq_out), .dq_oe(dq_oe), .four_bit_command_mode(four_bit_command_mode),
    .status_view(status_view), .write_in_progress(write_in_progress));
